// [rtl/see_target.sv]
// two-wire serial memory target: bus decode, page buffer, write cycle, array
`timescale 1ns/100ps
`default_nettype none
`include "see_params.svh"

module see_target #(
    parameter logic [3:0] DEV_TYPE = 4'h5, // arbitrary type code
    parameter int STRAP_MODE = `SEE_STRAP_PINS,
    parameter int ADDR_W = `SEE_ADDR_W,
    parameter int PAGE_W = `SEE_PAGE_W,
    parameter int WR_CYCLES = `SEE_NV_WRITE_CYCLE_TIME_NS / `SEE_CLK_PERIOD_NS
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe,
    input wire logic i_addr_strap_high,
    input wire logic i_addr_strap_mid,
    input wire logic i_addr_strap_low,
    input wire logic i_write_protect,
    output logic o_busy
);
    localparam int TW = $clog2(WR_CYCLES + 1);
    localparam int RW = ADDR_W - PAGE_W;
    localparam int PB = 1 << PAGE_W;
    localparam int FW = ADDR_W + 8;

    // ***************************************
    // pin synchronisers and condition detect
    // ***************************************
    logic [5:0] pin_m_q;
    logic [5:0] pin_s_q;
    logic scl_d_q;
    logic sda_d_q;
    logic scl_s;
    logic sda_s;
    logic wp_s;
    logic [2:0] strap_pins;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            pin_m_q <= 6'h3;
            pin_s_q <= 6'h3;
            scl_d_q <= 1'b1;
            sda_d_q <= 1'b1;
        end else if (i_ce) begin
            pin_m_q <= {i_addr_strap_high, i_addr_strap_mid, i_addr_strap_low,
                        i_write_protect, i_scl, i_sda};
            pin_s_q <= pin_m_q;
            scl_d_q <= pin_s_q[1];
            sda_d_q <= pin_s_q[0];
        end
    end

    assign sda_s = pin_s_q[0];
    assign scl_s = pin_s_q[1];
    assign wp_s = pin_s_q[2];
    assign strap_pins = pin_s_q[5:3];
    assign scl_rise = scl_s && !scl_d_q;
    assign scl_fall = !scl_s && scl_d_q;
    assign start_det = scl_s && scl_d_q && sda_d_q && !sda_s;
    assign stop_det = scl_s && scl_d_q && !sda_d_q && sda_s;

    // ***************************************
    // device word compare
    // ***************************************
    logic [2:0] strap_cmp;
    logic [2:0] strap_v;

    // strapless builds fix the compared value at elaboration
    generate
        if (STRAP_MODE == `SEE_STRAP_FIXED) begin : g_fixed
            assign strap_v = `SEE_STRAP_FIXED_VAL;
        end else if (STRAP_MODE == `SEE_STRAP_HIGH_ONLY) begin : g_high
            assign strap_v = {strap_pins[2], 2'h0};
        end else begin : g_pins
            assign strap_v = strap_pins;
        end
    endgenerate
    assign strap_cmp = strap_v;

    // ***************************************
    // bus protocol state
    // ***************************************
    see_pkg::see_state_t state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] rx_q;
    logic [7:0] tx_q;
    logic oe_q;
    logic sda_o_q;
    logic [PAGE_W-1:0] addr_hi_q;
    logic [ADDR_W-1:0] addr_cnt_q;
    logic [RW-1:0] row_q;
    logic have_data_q;
    logic [PB-1:0] valid_q;
    logic [7:0] page_q [PB];
    logic [7:0] mem_q [2**ADDR_W];
    logic [7:0] mem_rd;
    logic busy_q;
    logic commit_done_q;
    logic dev_match;

    assign mem_rd = mem_q[addr_cnt_q];
    assign dev_match = (rx_q[7:4] == DEV_TYPE) && (rx_q[3:1] == strap_cmp);

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state_q <= see_pkg::ST_IDLE;
            bit_cnt_q <= 4'h0;
            rx_q <= 8'h00;
            tx_q <= 8'h00;
            oe_q <= 1'b0;
            addr_hi_q <= '0;
            addr_cnt_q <= '0;
            row_q <= '0;
            have_data_q <= 1'b0;
        end else if (i_ce) begin
            if (start_det) begin
                state_q <= see_pkg::ST_DEVADDR;
                bit_cnt_q <= 4'h0;
                oe_q <= 1'b0;
                have_data_q <= 1'b0;
            end else if (stop_det) begin
                state_q <= see_pkg::ST_IDLE;
                oe_q <= 1'b0;
            end else if (state_q != see_pkg::ST_IDLE) begin
                if (scl_rise) begin
                    if (bit_cnt_q < `SEE_ACK_SLOT) begin
                        rx_q <= {rx_q[6:0], sda_s};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (bit_cnt_q == `SEE_ACK_SLOT) begin
                        bit_cnt_q <= `SEE_ACK_END;
                        if (state_q == see_pkg::ST_RDATA && sda_s) begin
                            state_q <= see_pkg::ST_IDLE;
                        end
                    end
                end else if (scl_fall) begin
                    if (bit_cnt_q == `SEE_ACK_SLOT) begin
                        case (state_q)
                            see_pkg::ST_DEVADDR: begin
                                if (dev_match && !busy_q) begin
                                    oe_q <= 1'b1;
                                    if (rx_q[`SEE_RW_BIT]) begin
                                        state_q <= see_pkg::ST_RDATA;
                                    end else begin
                                        state_q <= see_pkg::ST_ADDR_HI;
                                    end
                                end else begin
                                    oe_q <= 1'b0;
                                    state_q <= see_pkg::ST_IDLE;
                                end
                            end
                            see_pkg::ST_ADDR_HI: begin
                                addr_hi_q <= rx_q[PAGE_W-1:0];
                                oe_q <= 1'b1;
                                state_q <= see_pkg::ST_ADDR_LO;
                            end
                            see_pkg::ST_ADDR_LO: begin
                                addr_cnt_q <= {addr_hi_q, rx_q};
                                oe_q <= 1'b1;
                                state_q <= see_pkg::ST_WDATA;
                            end
                            see_pkg::ST_WDATA: begin
                                row_q <= addr_cnt_q[ADDR_W-1:PAGE_W];
                                addr_cnt_q[PAGE_W-1:0] <= addr_cnt_q[PAGE_W-1:0] + 1'b1;
                                have_data_q <= 1'b1;
                                oe_q <= 1'b1;
                            end
                            see_pkg::ST_RDATA: begin
                                oe_q <= 1'b0;
                            end
                            default: begin
                                oe_q <= 1'b0;
                            end
                        endcase
                    end else if (bit_cnt_q == `SEE_ACK_END) begin
                        bit_cnt_q <= 4'h0;
                        if (state_q == see_pkg::ST_RDATA) begin
                            tx_q <= mem_rd;
                            addr_cnt_q <= addr_cnt_q + 1'b1;
                            oe_q <= !mem_rd[7];
                        end else begin
                            oe_q <= 1'b0;
                        end
                    end else if (state_q == see_pkg::ST_RDATA && bit_cnt_q != 4'h0) begin
                        tx_q <= {tx_q[6:0], 1'b0};
                        oe_q <= !tx_q[6];
                    end
                end
            end
        end
    end

    // ***************************************
    // page buffer
    // ***************************************
    // the buffer holds bytes until the write cycle ends; a start while not busy drops them
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            valid_q <= '0;
        end else if (i_ce) begin
            if (commit_done_q || (start_det && !busy_q)) begin
                valid_q <= '0;
            end else if (state_q == see_pkg::ST_WDATA && scl_fall && !start_det
                         && !stop_det && bit_cnt_q == `SEE_ACK_SLOT) begin
                valid_q[addr_cnt_q[PAGE_W-1:0]] <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_ce && state_q == see_pkg::ST_WDATA && scl_fall && !start_det
            && !stop_det && bit_cnt_q == `SEE_ACK_SLOT) begin
            page_q[addr_cnt_q[PAGE_W-1:0]] <= rx_q;
        end
    end

    // ***************************************
    // self-timed write cycle
    // ***************************************
    logic [TW-1:0] timer_q;
    logic [PAGE_W:0] cidx_q;
    logic commit_go;
    logic push_valid;
    logic push_ready;
    logic pop_valid;
    logic [FW-1:0] pop_data;
    logic [1:0] pace_q;
    logic pop;

    assign commit_go = stop_det && state_q == see_pkg::ST_WDATA && have_data_q
                       && !wp_s;
    assign push_valid = busy_q && (cidx_q != `SEE_PAGE_BYTES)
                        && valid_q[cidx_q[PAGE_W-1:0]];

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            busy_q <= 1'b0;
            timer_q <= '0;
            cidx_q <= '0;
            commit_done_q <= 1'b0;
        end else if (i_ce) begin
            commit_done_q <= 1'b0;
            if (!busy_q && commit_go) begin
                busy_q <= 1'b1;
                timer_q <= TW'(WR_CYCLES - 1);
                cidx_q <= '0;
            end else if (busy_q) begin
                if (timer_q != '0) begin
                    timer_q <= timer_q - 1'b1;
                end
                if (cidx_q != `SEE_PAGE_BYTES && (!push_valid || push_ready)) begin
                    cidx_q <= cidx_q + 1'b1;
                end
                if (timer_q == '0 && cidx_q == `SEE_PAGE_BYTES && !pop_valid) begin
                    busy_q <= 1'b0;
                    commit_done_q <= 1'b1;
                end
            end
        end
    end

    // array programming is slower than the buffer walk, so the fifo fills
    assign pop = pop_valid && (pace_q == `SEE_DRAIN_GAP);

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            pace_q <= 2'h0;
        end else if (i_ce) begin
            pace_q <= pace_q + 2'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_ce && pop && !wp_s) begin
            mem_q[pop_data[FW-1:8]] <= pop_data[7:0];
        end
    end

    see_fifo #(
        .W(FW),
        .DEPTH(`SEE_FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_ce(i_ce),
        .i_in_valid(push_valid),
        .o_in_ready(push_ready),
        .i_in_data({row_q, cidx_q[PAGE_W-1:0], page_q[cidx_q[PAGE_W-1:0]]}),
        .o_out_valid(pop_valid),
        .i_out_ready(pop),
        .o_out_data(pop_data)
    );

    // ***************************************
    // outputs
    // ***************************************
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            sda_o_q <= 1'b0;
        end else if (i_ce) begin
            sda_o_q <= 1'b0;
        end
    end

    assign o_sda_o = sda_o_q;
    assign o_sda_oe = oe_q;
    assign o_busy = busy_q;

    // ***************************************
    // checks
    // ***************************************
    property p_oe_moves_scl_low;
        @(posedge i_clk) disable iff (!i_reset_n)
        $changed(oe_q) && !$past(start_det) && !$past(stop_det) |-> !scl_s;
    endproperty
    a_oe_moves_scl_low: assert property (p_oe_moves_scl_low) else $error("sda moved with scl high");

    property p_start_decodes;
        @(posedge i_clk) disable iff (!i_reset_n)
        start_det && i_ce |=> state_q == see_pkg::ST_DEVADDR && bit_cnt_q == 4'h0 && !oe_q;
    endproperty
    a_start_decodes: assert property (p_start_decodes) else $error("start not taken");

    property p_stop_idles;
        @(posedge i_clk) disable iff (!i_reset_n)
        stop_det && i_ce |=> state_q == see_pkg::ST_IDLE && !oe_q;
    endproperty
    a_stop_idles: assert property (p_stop_idles) else $error("stop did not idle");

    property p_addr_ack;
        @(posedge i_clk) disable iff (!i_reset_n)
        i_ce && scl_fall && !start_det && !stop_det && bit_cnt_q == `SEE_ACK_SLOT
        && state_q == see_pkg::ST_ADDR_HI |=> oe_q && state_q == see_pkg::ST_ADDR_LO;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address byte not acked");

    property p_type_mismatch;
        @(posedge i_clk) disable iff (!i_reset_n)
        i_ce && scl_fall && !start_det && !stop_det && bit_cnt_q == `SEE_ACK_SLOT
        && state_q == see_pkg::ST_DEVADDR && rx_q[7:4] != DEV_TYPE
        |=> !oe_q && state_q == see_pkg::ST_IDLE;
    endproperty
    a_type_mismatch: assert property (p_type_mismatch) else $error("foreign word acked");

    property p_busy_no_ack;
        @(posedge i_clk) disable iff (!i_reset_n)
        i_ce && busy_q && scl_fall && !start_det && !stop_det
        && bit_cnt_q == `SEE_ACK_SLOT && state_q == see_pkg::ST_DEVADDR |=> !oe_q;
    endproperty
    a_busy_no_ack: assert property (p_busy_no_ack) else $error("acked while busy");

    property p_wp_no_cycle;
        @(posedge i_clk) disable iff (!i_reset_n)
        i_ce && stop_det && wp_s && !busy_q |=> !busy_q;
    endproperty
    a_wp_no_cycle: assert property (p_wp_no_cycle) else $error("protected write began");

    property p_cycle_holds;
        @(posedge i_clk) disable iff (!i_reset_n)
        $rose(busy_q) |-> busy_q [*8];
    endproperty
    a_cycle_holds: assert property (p_cycle_holds) else $error("write cycle too short");

    property p_page_wrap;
        @(posedge i_clk) disable iff (!i_reset_n)
        i_ce && scl_fall && !start_det && !stop_det && bit_cnt_q == `SEE_ACK_SLOT
        && state_q == see_pkg::ST_WDATA
        |=> addr_cnt_q[ADDR_W-1:PAGE_W] == $past(addr_cnt_q[ADDR_W-1:PAGE_W])
        && addr_cnt_q[PAGE_W-1:0] == $past(addr_cnt_q[PAGE_W-1:0]) + 1'b1;
    endproperty
    a_page_wrap: assert property (p_page_wrap) else $error("page address wrong");

    property p_read_advance;
        @(posedge i_clk) disable iff (!i_reset_n)
        i_ce && scl_fall && !start_det && !stop_det && bit_cnt_q == `SEE_ACK_END
        && state_q == see_pkg::ST_RDATA
        |=> addr_cnt_q == $past(addr_cnt_q) + 1'b1 && tx_q == $past(mem_rd);
    endproperty
    a_read_advance: assert property (p_read_advance) else $error("read counter wrong");
endmodule

`default_nettype wire

// [rtl/see_params.svh]
// constants for the two-wire serial memory target
`ifndef SEE_PARAMS_SVH
`define SEE_PARAMS_SVH

// ***************************************
// geometry
// ***************************************
`define SEE_ADDR_W 13
`define SEE_PAGE_W 5
`define SEE_PAGE_BYTES 6'h20

// ***************************************
// timing
// ***************************************
`define SEE_NV_WRITE_CYCLE_TIME_NS 5000000
`define SEE_CLK_PERIOD_NS 100
`define SEE_DRAIN_GAP 2'h3

// ***************************************
// framing
// ***************************************
`define SEE_ACK_SLOT 4'h8
`define SEE_ACK_END 4'h9
`define SEE_RW_BIT 0
`define SEE_FIFO_DEPTH 8
`define SEE_STRAP_PINS 0
`define SEE_STRAP_HIGH_ONLY 1
`define SEE_STRAP_FIXED 2
`define SEE_STRAP_FIXED_VAL 3'h1

`endif

// [rtl/see_pkg.sv]
// types shared by the serial memory target
package see_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEVADDR,
        ST_ADDR_HI,
        ST_ADDR_LO,
        ST_WDATA,
        ST_RDATA
    } see_state_t;
endpackage

// [rtl/see_fifo.sv]
// first-in first-out buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none

module see_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [W-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [W-1:0] o_out_data
);
    // pointers wrap naturally, so depth must be a power of two
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_q != '0);
    assign o_out_data = mem_q[rd_q];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_ff @(posedge i_clk) begin
        if (i_ce && push) begin
            mem_q[wr_q] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else if (i_ce) begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// [verification/see_ctrl_model.sv]
// two-wire bus controller model facing the serial memory target
`timescale 1ns/100ps
`default_nettype none

module see_ctrl_model (
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low,
    output logic o_res_valid,
    output logic [7:0] o_res
);
    localparam int HALF = 400;

    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
        o_res_valid = 1'b0;
        o_res = 8'h00;
    end

    // ***************************************
    // bus primitives
    // ***************************************
    task automatic report(input logic [7:0] v);
        o_res = v;
        o_res_valid = 1'b1;
        #10 o_res_valid = 1'b0;
    endtask

    // repeated start first lifts sda during clock low
    task automatic start();
        if (o_scl === 1'b0) begin
            #(HALF/2) o_sda_low = 1'b0;
            #(HALF/2) o_scl = 1'b1;
        end
        #(HALF) o_sda_low = 1'b1;
        #(HALF) o_scl = 1'b0;
    endtask

    task automatic stop();
        #(HALF/2) o_sda_low = 1'b1;
        #(HALF/2) o_scl = 1'b1;
        #(HALF) o_sda_low = 1'b0;
        #(HALF);
    endtask

    // data moves mid-low, sampled late in high so slow answers still count
    task automatic bit_io(input logic drive, output logic seen);
        #(HALF/2) o_sda_low = ~drive;
        #(HALF/2) o_scl = 1'b1;
        #(HALF) seen = i_sda;
        o_scl = 1'b0;
    endtask

    task automatic wbyte(input logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(v[i], s);
        bit_io(1'b1, s);
        report({7'h00, s});
    endtask

    task automatic rbyte(input logic ack);
        logic [7:0] v;
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            v[i] = s;
        end
        bit_io(~ack, s);
        report(v);
    endtask

    task automatic recover();
        logic s;
        start();
        repeat (9) bit_io(1'b1, s);
        start();
        stop();
    endtask
endmodule

`default_nettype wire

// [verification/testbench.sv]
// self-checking bench for the two-wire serial memory target
`timescale 1ns/100ps
`default_nettype none

module testbench;
    localparam logic [3:0] TYPE = 4'h5; // arbitrary type code
    localparam int WR_CYC = 200;
    logic i_clk, i_reset_n, i_ce, i_write_protect, scl, sda_low, sda, res_valid, o_sda_o, o_sda_oe;
    logic o_busy;
    logic [7:0] res;
    logic [2:0] strap;
    logic [15:0] a;
    logic [12:0] cur;
    logic [7:0] mem [0:8191];
    logic [7:0] exp_q[$];
    integer seed = 16;
    int error_cnt = 0;
    int checked = 0;

    // open drain with pull-up
    assign sda = (sda_low || o_sda_oe === 1'b1) ? 1'b0 : 1'b1;

    see_target #(.DEV_TYPE(TYPE), .WR_CYCLES(WR_CYC)) i_see_target (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(i_ce), .i_scl(scl), .i_sda(sda),
        .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .i_addr_strap_high(strap[2]),
        .i_addr_strap_mid(strap[1]), .i_addr_strap_low(strap[0]),
        .i_write_protect(i_write_protect), .o_busy(o_busy));

    see_ctrl_model i_see_ctrl_model (.i_sda(sda), .o_scl(scl), .o_sda_low(sda_low),
        .o_res_valid(res_valid), .o_res(res));

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    // ***************************************
    // checking
    // ***************************************
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] e);
        checked++;
        if (seen !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, e, seen);
        end
    endtask

    always @(posedge res_valid) begin
        check("bus", res, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx);
    end

    always @(posedge i_clk) begin
        if (o_sda_oe === 1'b1)
            check("drive level", {7'h00, o_sda_o}, 8'h00);
    end

    task automatic results();
        $display("counts: checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ***************************************
    // transfers
    // ***************************************
    task automatic dev(input logic rw, input logic [7:0] e);
        // keep bus edges off the sampling edge of the clock
        @(posedge i_clk);
        #1;
        i_see_ctrl_model.start();
        exp_q.push_back(e);
        i_see_ctrl_model.wbyte({TYPE, strap, rw});
    endtask

    task automatic set_addr(input logic [15:0] ad);
        dev(1'b0, 8'h00);
        exp_q.push_back(8'h00);
        i_see_ctrl_model.wbyte(ad[15:8]);
        exp_q.push_back(8'h00);
        i_see_ctrl_model.wbyte(ad[7:0]);
        cur = ad[12:0];
    endtask

    task automatic settle(input logic busy_exp);
        int k;
        repeat (3) @(posedge i_clk);
        check("busy", {7'h00, o_busy}, {7'h00, busy_exp});
        if (busy_exp) begin
            dev(1'b0, 8'h01);
            i_see_ctrl_model.stop();
        end
        k = 0;
        while (o_busy !== 1'b0 && k < 2000) begin
            @(posedge i_clk);
            k++;
        end
        check("busy end", {7'h00, o_busy}, 8'h00);
    endtask

    task automatic wr(input logic [15:0] ad, input int n);
        logic [7:0] d;
        set_addr(ad);
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            if (!i_write_protect)
                mem[{ad[12:5], ad[4:0] + 5'(i)}] = d;
            exp_q.push_back(8'h00);
            i_see_ctrl_model.wbyte(d);
        end
        i_see_ctrl_model.stop();
        settle(!i_write_protect);
    endtask

    task automatic rd(input int n);
        dev(1'b1, 8'h00);
        for (int i = 1; i <= n; i++) begin
            exp_q.push_back(mem[cur]);
            cur = cur + 13'h1;
            i_see_ctrl_model.rbyte(i < n);
        end
        i_see_ctrl_model.stop();
    endtask

    initial begin
        #4000000;
        error_cnt++;
        results();
    end

    // ***************************************
    // scenarios
    // ***************************************
    initial begin
        i_reset_n = 1'b0;
        i_ce = 1'b1;
        i_write_protect = 1'b0;
        strap = 3'($random(seed));
        repeat (10) @(posedge i_clk);
        #1 i_reset_n = 1'b1;
        repeat (4) @(posedge i_clk);
        #1;
        i_see_ctrl_model.recover();
        for (int t = 0; t < 4; t++) begin
            i_see_ctrl_model.start();
            exp_q.push_back(8'h01);
            i_see_ctrl_model.wbyte((t == 3) ? {TYPE ^ 4'ha, strap, 1'b0}
                : {TYPE, strap ^ (3'h1 << t), 1'b0});
            i_see_ctrl_model.stop();
        end
        $display("test address match done");
        a = 16'($random(seed));
        wr(a, 34);
        set_addr({3'h0, a[12:5], 5'h00});
        rd(32);
        $display("test page write done");
        wr(16'hffff, 1);
        wr(16'h0000, 2);
        set_addr(16'h1fff);
        rd(2);
        rd(1);
        $display("test wrap and current read done");
        @(posedge i_clk);
        #1 i_write_protect = 1'b1;
        wr(a, 1);
        @(posedge i_clk);
        #1 i_write_protect = 1'b0;
        set_addr(a);
        rd(1);
        $display("test write protect done");
        set_addr(a);
        exp_q.push_back(8'h00);
        i_see_ctrl_model.wbyte(8'($random(seed)));
        i_see_ctrl_model.start();
        i_see_ctrl_model.stop();
        settle(1'b0);
        set_addr(a);
        rd(1);
        $display("test abandoned write done");
        repeat (10) @(posedge i_clk);
        check("pending", 8'(exp_q.size()), 8'h00);
        results();
    end
endmodule

`default_nettype wire
